// *** rtl/fcc_map.svh ***
`ifndef FCC_MAP_SVH
`define FCC_MAP_SVH

// ---------------------------------------------------------------
// Clock and bus timing
// ---------------------------------------------------------------
`define FCC_CLK_NS      20
`define FCC_T_ACC_NS    120
`define FCC_T_SU_NS     50
`define FCC_T_WP_NS     50
`define FCC_T_REC_NS    20
`define FCC_SYNC_CYC    2
`define FCC_SU_CYC  ((`FCC_T_SU_NS + `FCC_CLK_NS - 1) / `FCC_CLK_NS)
`define FCC_WP_CYC  ((`FCC_T_WP_NS + `FCC_CLK_NS - 1) / `FCC_CLK_NS)
`define FCC_ACC_CYC ((`FCC_T_ACC_NS + `FCC_CLK_NS - 1) / `FCC_CLK_NS)
`define FCC_REC_CYC ((`FCC_T_REC_NS + `FCC_CLK_NS - 1) / `FCC_CLK_NS)

// ---------------------------------------------------------------
// Command bytes
// ---------------------------------------------------------------
`define FCC_CMD_READ_ARRAY   8'hff
`define FCC_CMD_READ_ID      8'h90
`define FCC_CMD_READ_STATUS  8'h70
`define FCC_CMD_CLEAR_STATUS 8'h50
`define FCC_CMD_ERASE_SETUP  8'h20
`define FCC_CMD_ERASE_CONF   8'hd0
`define FCC_CMD_PROG_SETUP   8'h40

// ---------------------------------------------------------------
// Status bit positions
// ---------------------------------------------------------------
`define FCC_SR_READY      7
`define FCC_SR_ERASE_ERR  5
`define FCC_SR_PROG_ERR   4
`define FCC_SR_SUPPLY_LOW 3
`define FCC_SR_LOCK_VIOL  1

`endif

// *** rtl/fcc_pkg.sv ***
package fcc_pkg;

    typedef enum logic [2:0] {
        OP_READ_ARRAY,
        OP_READ_ID,
        OP_READ_STATUS,
        OP_CLEAR_STATUS,
        OP_ERASE,
        OP_PROGRAM
    } fcc_op_t;

    typedef enum logic [1:0] {
        MODE_ARRAY,
        MODE_ID,
        MODE_STATUS
    } fcc_mode_t;

endpackage

// *** rtl/fcc_cyc_if.sv ***
`timescale 1ns/1ps
`default_nettype none

interface fcc_cyc_if #(parameter int ADDR_W = 21);
    logic              go;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
    logic              done;
    logic [7:0]        rdata;

    modport master (output go, wr, addr, wdata, input done, rdata);
    modport engine (input go, wr, addr, wdata, output done, rdata);
endinterface

`default_nettype wire

// *** rtl/fcc_cycle.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "fcc_map.svh"

module fcc_cycle
    import fcc_pkg::*;
#(
    parameter int ADDR_W = 21
)
(
    input  wire logic              clk,    // System clock
    input  wire logic              rst_n,  // Async reset, active low
    fcc_cyc_if.engine              cyc,    // Cycle requests
    output var  logic              ce_n,   // Chip select
    output var  logic              oe_n,   // Output enable
    output var  logic              we_n,   // Write strobe
    output var  logic [ADDR_W-1:0] addr,   // Address pins
    output var  logic [7:0]        dq_o,   // Data out
    output var  logic              dq_oe,  // Data drive enable
    input  wire logic [7:0]        dq_i    // Data in from pins
);

    typedef enum {E_IDLE, E_SETUP, E_PULSE, E_HOLD, E_RECOV} fcc_eng_t;

    fcc_eng_t   state_reg;
    logic [3:0] cnt_reg;
    logic       wr_reg;
    logic [7:0] dq_s1_reg;
    logic [7:0] dq_s2_reg;

    // ---------------------------------------------------------------
    // Data pin synchroniser
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dq_s1_reg <= 8'h00;
            dq_s2_reg <= 8'h00;
        end
        else
        begin
            dq_s1_reg <= dq_i;
            dq_s2_reg <= dq_s1_reg;
        end
    end

    // ---------------------------------------------------------------
    // Bus cycle sequencer
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= E_IDLE;
            cnt_reg   <= 4'h0;
            wr_reg    <= 1'b0;
            ce_n      <= 1'b1;
            oe_n      <= 1'b1;
            we_n      <= 1'b1;
            addr      <= '0;
            dq_o      <= 8'h00;
            dq_oe     <= 1'b0;
            cyc.done  <= 1'b0;
            cyc.rdata <= 8'h00;
        end
        else
        begin
            cyc.done <= 1'b0;
            case (state_reg)
                E_IDLE:
                    if (cyc.go)
                    begin
                        addr      <= cyc.addr;
                        dq_o      <= cyc.wdata;
                        wr_reg    <= cyc.wr;
                        dq_oe     <= cyc.wr;
                        ce_n      <= 1'b0;
                        cnt_reg   <= 4'(`FCC_SU_CYC);
                        state_reg <= E_SETUP;
                    end
                E_SETUP:
                    if (cnt_reg <= 4'h1)
                    begin
                        if (wr_reg)
                        begin
                            we_n    <= 1'b0;
                            cnt_reg <= 4'(`FCC_WP_CYC);
                        end
                        else
                        begin
                            oe_n    <= 1'b0;
                            cnt_reg <= 4'(`FCC_ACC_CYC + `FCC_SYNC_CYC);
                        end
                        state_reg <= E_PULSE;
                    end
                    else
                        cnt_reg <= cnt_reg - 4'h1;
                E_PULSE:
                    if (cnt_reg <= 4'h1)
                    begin
                        // Strobe rises while data still driven
                        we_n <= 1'b1;
                        oe_n <= 1'b1;
                        if (!wr_reg)
                            cyc.rdata <= dq_s2_reg;
                        state_reg <= E_HOLD;
                    end
                    else
                        cnt_reg <= cnt_reg - 4'h1;
                E_HOLD:
                begin
                    // Every cycle ends with strobes high again
                    ce_n      <= 1'b1;
                    dq_oe     <= 1'b0;
                    cnt_reg   <= 4'(`FCC_REC_CYC);
                    state_reg <= E_RECOV;
                end
                E_RECOV:
                    if (cnt_reg <= 4'h1)
                    begin
                        cyc.done  <= 1'b1;
                        state_reg <= E_IDLE;
                    end
                    else
                        cnt_reg <= cnt_reg - 4'h1;
                default:
                    state_reg <= E_IDLE;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    a_wr_data_hold: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(we_n) |-> dq_oe)
        else $error("write data released before strobe rose");
    a_strobe_release: assert property (@(posedge clk) disable iff (!rst_n)
        cyc.done |-> ce_n && oe_n && we_n && !dq_oe)
        else $error("strobes not high at cycle end");

endmodule // fcc_cycle

`default_nettype wire

// *** rtl/fcc_ctrl.sv ***
// Notes on behaviour
// - Identifier mode persists; host skips rewriting the command for repeated reads.
// - Status captured at strobe fall; host raises strobes between every read.
// - Erase is setup then confirm, both at an address inside the block.
// - Program is setup 40H or 10H, then address and byte write.
// - After erase, host checks erase error and clears status on error.
// - After program, host checks program error and clears status if set.
`timescale 1ns/1ps
`default_nettype none
`include "fcc_map.svh"

module fcc_ctrl
    import fcc_pkg::*;
#(
    parameter int ADDR_W = 21
)
(
    input  wire logic              CLOCK,           // 50 MHz clock
    input  wire logic              RESETN,          // Async reset
    input  wire logic              CMD_VALID,       // Request strobe
    input  wire logic [2:0]        CMD_OP,          // Operation code
    input  wire logic [ADDR_W-1:0] CMD_ADDR,        // Target address
    input  wire logic [7:0]        CMD_DATA,        // Program byte
    input  wire logic              PWRDN_REQ,       // Hold device down
    output var  logic              CMD_READY,       // Idle, takes request
    output var  logic              RESP_VALID,      // Result pulse
    output var  logic [7:0]        RESP_DATA,       // Read byte/status
    output var  logic              RESP_ERROR,      // Operation failed
    output var  logic              FL_CE_N,         // Chip select
    output var  logic              FL_OE_N,         // Output enable
    output var  logic              FL_WE_N,         // Write strobe
    output var  logic              FL_RESET_POWERDOWN_N, // Reset pin
    output var  logic [ADDR_W-1:0] FL_ADDR,         // Address pins
    output var  logic [7:0]        FL_DQ_O,         // Data out
    output var  logic              FL_DQ_OE,        // Data drive enable
    input  wire logic [7:0]        FL_DQ_I,         // Data in
    input  wire logic              FL_READY_BUSY_N  // Ready/busy pin
);

    typedef enum {M_IDLE, M_CMD, M_DATA, M_POLL, M_CLEAR, M_READ,
                  M_DONE} fcc_main_t;

    fcc_cyc_if #(.ADDR_W(ADDR_W)) cyc ();

    fcc_main_t         state_reg;
    fcc_op_t           op_reg;
    fcc_mode_t         mode_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [7:0]        data_reg;
    logic [7:0]        result_reg;
    logic              err_reg;
    logic              go_reg;
    logic              wr_reg;
    logic [7:0]        wdata_reg;
    logic              rb_s1_reg;
    logic              rb_s2_reg;
    fcc_op_t           op_in;
    logic              accept;
    logic              poll_ready;
    logic              poll_err;

    assign op_in      = fcc_op_t'(CMD_OP);
    assign accept     = (state_reg == M_IDLE) && CMD_VALID && !PWRDN_REQ;
    assign poll_ready = cyc.rdata[`FCC_SR_READY] && rb_s2_reg;
    assign poll_err   = (op_reg == OP_ERASE) ?
                        cyc.rdata[`FCC_SR_ERASE_ERR] :
                        cyc.rdata[`FCC_SR_PROG_ERR];

    assign cyc.go    = go_reg;
    assign cyc.wr    = wr_reg;
    assign cyc.addr  = addr_reg;
    assign cyc.wdata = wdata_reg;

    function automatic fcc_mode_t mode_of(input fcc_op_t op);
        case (op)
            OP_READ_ID:     mode_of = MODE_ID;
            OP_READ_STATUS: mode_of = MODE_STATUS;
            default:        mode_of = MODE_ARRAY;
        endcase
    endfunction

    function automatic logic [7:0] cmd_of(input fcc_op_t op);
        case (op)
            OP_READ_ID:      cmd_of = `FCC_CMD_READ_ID;
            OP_READ_STATUS:  cmd_of = `FCC_CMD_READ_STATUS;
            OP_CLEAR_STATUS: cmd_of = `FCC_CMD_CLEAR_STATUS;
            OP_ERASE:        cmd_of = `FCC_CMD_ERASE_SETUP;
            OP_PROGRAM:      cmd_of = `FCC_CMD_PROG_SETUP;
            default:         cmd_of = `FCC_CMD_READ_ARRAY;
        endcase
    endfunction

    // ---------------------------------------------------------------
    // Bus cycle engine
    // ---------------------------------------------------------------
    fcc_cycle #(.ADDR_W(ADDR_W)) u_cycle (
        .clk   (CLOCK),
        .rst_n (RESETN),
        .cyc   (cyc.engine),
        .ce_n  (FL_CE_N),
        .oe_n  (FL_OE_N),
        .we_n  (FL_WE_N),
        .addr  (FL_ADDR),
        .dq_o  (FL_DQ_O),
        .dq_oe (FL_DQ_OE),
        .dq_i  (FL_DQ_I)
    );

    // ---------------------------------------------------------------
    // Ready/busy synchroniser
    // ---------------------------------------------------------------
    always_ff @(posedge CLOCK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            rb_s1_reg <= 1'b0;
            rb_s2_reg <= 1'b0;
        end
        else
        begin
            rb_s1_reg <= FL_READY_BUSY_N;
            rb_s2_reg <= rb_s1_reg;
        end
    end

    // ---------------------------------------------------------------
    // Power-down pin and tracked device mode
    // ---------------------------------------------------------------
    always_ff @(posedge CLOCK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            FL_RESET_POWERDOWN_N <= 1'b0;
            mode_reg             <= MODE_ARRAY;
        end
        else
        begin
            if (state_reg == M_IDLE)
                FL_RESET_POWERDOWN_N <= !PWRDN_REQ;
            if (!FL_RESET_POWERDOWN_N)
                mode_reg <= MODE_ARRAY;
            else if (state_reg == M_CMD && cyc.done &&
                     op_reg != OP_CLEAR_STATUS)
                mode_reg <= mode_of(op_reg);
            else if (state_reg == M_DATA && cyc.done)
                mode_reg <= MODE_STATUS;
        end
    end

    // ---------------------------------------------------------------
    // Operation sequencer
    // ---------------------------------------------------------------
    always_ff @(posedge CLOCK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            state_reg  <= M_IDLE;
            op_reg     <= OP_READ_ARRAY;
            addr_reg   <= '0;
            data_reg   <= 8'h00;
            wdata_reg  <= 8'h00;
            wr_reg     <= 1'b0;
            go_reg     <= 1'b0;
            result_reg <= 8'h00;
            err_reg    <= 1'b0;
        end
        else
        begin
            go_reg <= 1'b0;
            case (state_reg)
                M_IDLE:
                    if (accept)
                    begin
                        op_reg   <= op_in;
                        addr_reg <= CMD_ADDR;
                        data_reg <= CMD_DATA;
                        err_reg  <= 1'b0;
                        go_reg   <= 1'b1;
                        if (op_in <= OP_READ_STATUS &&
                            mode_reg == mode_of(op_in))
                        begin
                            // Mode already set: read straight away
                            wr_reg    <= 1'b0;
                            state_reg <= M_READ;
                        end
                        else
                        begin
                            wr_reg    <= 1'b1;
                            wdata_reg <= cmd_of(op_in);
                            state_reg <= M_CMD;
                        end
                    end
                M_CMD:
                    if (cyc.done)
                    begin
                        go_reg <= (op_reg != OP_CLEAR_STATUS);
                        if (op_reg == OP_ERASE)
                            wdata_reg <= `FCC_CMD_ERASE_CONF;
                        else
                            wdata_reg <= data_reg;
                        if (op_reg == OP_CLEAR_STATUS)
                            state_reg <= M_DONE;
                        else if (op_reg <= OP_READ_STATUS)
                        begin
                            wr_reg    <= 1'b0;
                            state_reg <= M_READ;
                        end
                        else
                            state_reg <= M_DATA;
                    end
                M_DATA:
                    if (cyc.done)
                    begin
                        wr_reg    <= 1'b0;
                        go_reg    <= 1'b1;
                        state_reg <= M_POLL;
                    end
                M_POLL:
                    if (cyc.done)
                    begin
                        // Each poll is a fresh strobed read
                        if (!poll_ready)
                            go_reg <= 1'b1;
                        else
                        begin
                            result_reg <= cyc.rdata;
                            err_reg    <= poll_err;
                            if (poll_err)
                            begin
                                wr_reg    <= 1'b1;
                                go_reg    <= 1'b1;
                                wdata_reg <= `FCC_CMD_CLEAR_STATUS;
                                state_reg <= M_CLEAR;
                            end
                            else
                                state_reg <= M_DONE;
                        end
                    end
                M_CLEAR:
                    if (cyc.done)
                        state_reg <= M_DONE;
                M_READ:
                    if (cyc.done)
                    begin
                        result_reg <= cyc.rdata;
                        state_reg  <= M_DONE;
                    end
                M_DONE:
                    state_reg <= M_IDLE;
                default:
                    state_reg <= M_IDLE;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // User answer
    // ---------------------------------------------------------------
    always_ff @(posedge CLOCK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            CMD_READY  <= 1'b0;
            RESP_VALID <= 1'b0;
            RESP_DATA  <= 8'h00;
            RESP_ERROR <= 1'b0;
        end
        else
        begin
            CMD_READY  <= (state_reg == M_IDLE) && !accept && !PWRDN_REQ
                          || (state_reg == M_DONE && !PWRDN_REQ);
            RESP_VALID <= (state_reg == M_DONE);
            if (state_reg == M_DONE)
            begin
                RESP_DATA  <= result_reg;
                RESP_ERROR <= err_reg;
            end
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    a_erase_confirm: assert property (@(posedge CLOCK) disable iff (!RESETN)
        state_reg == M_DATA && op_reg == OP_ERASE && go_reg
        |-> wdata_reg == 8'hd0 && wr_reg)
        else $error("erase confirm byte wrong");
    a_erase_same_addr: assert property (@(posedge CLOCK) disable iff (!RESETN)
        state_reg == M_CMD && op_reg == OP_ERASE && cyc.done
        |=> state_reg == M_DATA && $stable(addr_reg))
        else $error("erase confirm address moved");
    a_prog_setup: assert property (@(posedge CLOCK) disable iff (!RESETN)
        state_reg == M_CMD && op_reg == OP_PROGRAM && go_reg
        |-> wdata_reg == 8'h40)
        else $error("program setup byte wrong");
    a_prog_byte: assert property (@(posedge CLOCK) disable iff (!RESETN)
        state_reg == M_DATA && op_reg == OP_PROGRAM && go_reg
        |-> wdata_reg == data_reg)
        else $error("program data byte wrong");
    a_erase_clear: assert property (@(posedge CLOCK) disable iff (!RESETN)
        state_reg == M_POLL && op_reg == OP_ERASE && cyc.done
        && poll_ready && cyc.rdata[5]
        |=> state_reg == M_CLEAR && wdata_reg == 8'h50)
        else $error("erase error not cleared");
    a_prog_clear: assert property (@(posedge CLOCK) disable iff (!RESETN)
        state_reg == M_POLL && op_reg == OP_PROGRAM && cyc.done
        && poll_ready && cyc.rdata[4]
        |=> state_reg == M_CLEAR ##[1:40] state_reg == M_DONE)
        else $error("program error not cleared");
    a_id_persist: assert property (@(posedge CLOCK) disable iff (!RESETN)
        accept && op_in == OP_READ_ID && mode_reg == MODE_ID
        |=> state_reg == M_READ && !wr_reg)
        else $error("identifier command rewritten");

    c_erase_ok: cover property (@(posedge CLOCK)
        RESP_VALID && op_reg == OP_ERASE && !RESP_ERROR);
    c_prog_err: cover property (@(posedge CLOCK)
        RESP_VALID && op_reg == OP_PROGRAM && RESP_ERROR);
    c_id_reread: cover property (@(posedge CLOCK)
        accept && op_in == OP_READ_ID && mode_reg == MODE_ID);

endmodule // fcc_ctrl

`default_nettype wire

// *** verification/fcc_flash_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------
// Flash device model, two 8-byte blocks
// ------------------------------------
module fcc_flash_model #(
    parameter logic [7:0] MAKER = 8'h5a, // Arbitrary value
    parameter logic [7:0] PART  = 8'h3c  // Arbitrary value
)(
    input  wire logic        ce_n,    // Chip select
    input  wire logic        oe_n,    // Output enable
    input  wire logic        we_n,    // Write strobe
    input  wire logic        rp_n,    // Reset/power-down
    input  wire logic        vpp_low, // Supply at lockout
    input  wire logic [20:0] addr,    // Address
    input  wire logic [7:0]  din,     // Bus level
    output var  logic [7:0]  dout,    // Read drive
    output var  logic        rb_n     // Ready/busy
);
    logic [7:0] mem [16];
    logic [7:0] sr = 8'h80, lat = 8'h00, pend = 8'h00, p, e, dd;
    logic [1:0] mode = 2'd0;
    logic [3:0] ix, a4;
    assign ix = {addr[16], addr[2:0]};
    initial rb_n = 1'b1;
    // Block 0 starts erased, block 1 holds zeros so a stray erase shows
    initial foreach (mem[i]) mem[i] = i < 8 ? 8'hff : 8'h00;
    always @(negedge rp_n) mode = 2'd0;
    always @(negedge oe_n or negedge ce_n)
        if (!ce_n && !oe_n)
            lat = mode == 2'd2 ? sr : mode == 2'd0 ? mem[ix] :
                  addr[1:0] == 2'd0 ? MAKER : addr[1:0] == 2'd1 ? PART :
                  {7'h00, addr[1:0] == 2'd2 && addr[16]};
    // Released bus shows the inverse, never a stale byte
    assign dout = (!ce_n && !oe_n) ? lat : ~lat;
    always @(posedge we_n)
        if (!ce_n && rp_n)
        begin
            p = pend;
            pend = 8'h00;
            mode = 2'd2;
            e = 8'h00;
            if (p == 8'h20)
                e = din != 8'hd0 ? 8'h30 : vpp_low ? 8'h28 :
                    addr[16] ? 8'h22 : 8'h00;
            else if (p != 8'h00)
                e = vpp_low ? 8'h28 : addr[16] ? 8'h12 : 8'h00;
            else if (din == 8'hff)
                mode = 2'd0;
            else if (din == 8'h90)
                mode = 2'd1;
            else if (din == 8'h50)
                sr = 8'h80;
            else if (din inside {8'h20, 8'h40, 8'h10})
                pend = din;
            sr = sr | e;
            if (p != 8'h00 && e == 8'h00)
            begin
                a4 = ix;
                dd = din;
                rb_n = 1'b0;
                sr[7] = 1'b0;
                #400;
                for (int i = 0; i < 8; i++)
                    if (p == 8'h20)
                        mem[{a4[3], i[2:0]}] = 8'hff;
                if (p != 8'h20)
                    mem[a4] = mem[a4] & dd;
                sr[7] = 1'b1;
                rb_n = 1'b1;
            end
        end
endmodule // fcc_flash_model
`default_nettype wire

// *** verification/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------
// Controller bench against flash model
// ------------------------------------
module tb;
    logic             clk = 1'b0, rst_n = 1'b0, valid = 1'b0;
    logic             pd = 1'b0, vpp_low = 1'b0;
    logic [2:0]       op = 3'd0;
    logic [20:0]      a = 21'h0;
    logic [7:0]       d = 8'h00;
    wire logic        rdy, rv, rerr, ce_n, oe_n, we_n, rp_n, dq_oe, rb_n;
    wire logic [7:0]  rdata, dq_o, m_out, dq;
    wire logic [20:0] fa;
    int               failures = 0, cmp_count = 0;
    assign dq = dq_oe ? dq_o : m_out;
    always #10 clk = ~clk;
    fcc_ctrl dut_u (.CLOCK(clk), .RESETN(rst_n), .CMD_VALID(valid),
        .CMD_OP(op), .CMD_ADDR(a), .CMD_DATA(d), .PWRDN_REQ(pd),
        .CMD_READY(rdy), .RESP_VALID(rv), .RESP_DATA(rdata),
        .RESP_ERROR(rerr), .FL_CE_N(ce_n), .FL_OE_N(oe_n), .FL_WE_N(we_n),
        .FL_RESET_POWERDOWN_N(rp_n), .FL_ADDR(fa), .FL_DQ_O(dq_o),
        .FL_DQ_OE(dq_oe), .FL_DQ_I(dq), .FL_READY_BUSY_N(rb_n));
    fcc_flash_model flash_u (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
        .rp_n(rp_n), .vpp_low(vpp_low), .addr(fa), .din(dq),
        .dout(m_out), .rb_n(rb_n));
    task automatic step;
        @(posedge clk);
        #1;
    endtask
    task automatic chk(input string w, input logic [7:0] exp, got);
        cmp_count++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", w, exp, got);
        end
    endtask
    task automatic req(input logic [2:0] o, input logic [20:0] ad,
                       input logic [7:0] dt);
        for (int n = 0; n < 5000 && rdy !== 1'b1; n++)
            step;
        valid = 1'b1;
        op = o;
        a = ad;
        d = dt;
        step;
        valid = 1'b0;
        for (int n = 0; n < 5000 && rv !== 1'b1; n++)
            step;
        chk("resp", 8'h01, {7'h00, rv});
    endtask
    task automatic rd(input string w, input logic [2:0] o,
                      input logic [20:0] ad, input logic [7:0] exp);
        req(o, ad, 8'h00);
        chk(w, exp, rdata);
    endtask
    task automatic t_id;
        rd("maker", 3'd1, 21'h0, 8'h5a);
        rd("part", 3'd1, 21'h1, 8'h3c);
        rd("lock1", 3'd1, 21'h10002, 8'h01);
        rd("lock0", 3'd1, 21'h2, 8'h00);
        rd("master", 3'd1, 21'h3, 8'h00);
    endtask
    task automatic t_prog;
        req(3'd5, 21'h5, 8'ha5);
        chk("prog sr", 8'h80, rdata);
        rd("array", 3'd0, 21'h5, 8'ha5);
        req(3'd5, 21'h5, 8'h5f);
        chk("verify", 8'h00, {7'h00, rerr});
        rd("kept bits", 3'd0, 21'h5, 8'h05);
        rd("status", 3'd2, 21'h3, 8'h80);
    endtask
    task automatic t_fail;
        vpp_low = 1'b1;
        req(3'd4, 21'h0, 8'h00);
        chk("low erase", 8'ha8, rdata);
        chk("low erase err", 8'h01, {7'h00, rerr});
        rd("unerased", 3'd0, 21'h5, 8'h05);
        req(3'd5, 21'h6, 8'h00);
        chk("low prog", 8'ha8, rdata);
        rd("sticky", 3'd2, 21'h0, 8'ha8);
        req(3'd3, 21'h0, 8'h00);
        rd("cleared", 3'd2, 21'h0, 8'h80);
        vpp_low = 1'b0;
        req(3'd4, 21'h10000, 8'h00);
        chk("lock erase", 8'ha2, rdata);
        req(3'd5, 21'h10001, 8'h00);
        chk("lock prog", 8'h92, rdata);
        chk("lock prog err", 8'h01, {7'h00, rerr});
        rd("recovered", 3'd2, 21'h0, 8'h80);
    endtask
    task automatic t_erase;
        req(3'd4, 21'h1, 8'h00);
        chk("erase sr", 8'h80, rdata);
        rd("erased", 3'd0, 21'h5, 8'hff);
        rd("other blk", 3'd0, 21'h10005, 8'h00);
    endtask
    task automatic t_pd;
        rd("id again", 3'd1, 21'h0, 8'h5a);
        pd = 1'b1;
        repeat (4) step;
        chk("rp pin", 8'h00, {7'h00, rp_n});
        pd = 1'b0;
        rd("array mode", 3'd0, 21'h5, 8'hff);
    endtask
    task automatic print_verdict;
        $display("checks %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        #600000;
        failures++;
        print_verdict;
    end
    initial
    begin
        repeat (5) @(posedge clk);
        #1;
        rst_n = 1'b1;
        step;
        t_id;
        t_prog;
        t_fail;
        t_erase;
        t_pd;
        print_verdict;
    end
endmodule // tb
`default_nettype wire
